/* core/iops_consts.svh */
// Constants of the I/O port select, serial and test-port block
`ifndef IOPS_CONSTS_SVH
`define IOPS_CONSTS_SVH

// Port addresses
`define IOPS_PORT_AUX_STATUS_CONTROL 8'hcc
`define IOPS_PORT_AUX_DATA 8'hcd
`define IOPS_PORT_TERM_STATUS_CONTROL 8'hce
`define IOPS_PORT_TERM_DATA 8'hcf
`define IOPS_PORT_LINK_DATA 8'he8
`define IOPS_PORT_LINK_STATUS_CONTROL 8'he9
`define IOPS_PORT_TEST_STATUS_CONTROL 8'hea
`define IOPS_PORT_TEST_DATA 8'heb

// Decoder fields: pair select on addr[7:1], range select on addr[7:3], sub-port on addr[2:0]
`define IOPS_AUX_PAIR 7'h66
`define IOPS_TERM_PAIR 7'h67
`define IOPS_RANGE_BLOCK 5'h1d
`define IOPS_SUB_LINK_DATA 3'h0
`define IOPS_SUB_LINK_STAT 3'h1
`define IOPS_SUB_TEST_STAT 3'h2
`define IOPS_SUB_TEST_DATA 3'h3

// Timing
`define IOPS_CLK_HZ 40000000
`define IOPS_LINK_BAUD 153600
`define IOPS_ADAPTER_DIV 16
`define IOPS_OVERSAMPLE 16
`define IOPS_RATE_0 110
`define IOPS_RATE_1 150
`define IOPS_RATE_2 300
`define IOPS_RATE_3 600
`define IOPS_RATE_4 1200
`define IOPS_RATE_5 2400
`define IOPS_RATE_6 4800
`define IOPS_RATE_7 9600
`define IOPS_DATA_BITS 8

// Link control latch bits
`define IOPS_CTL_PARITY_EN 0
`define IOPS_CTL_PARITY_ODD 1
`define IOPS_CTL_TWO_STOP 2

// Link status byte bits
`define IOPS_ST_RX_READY 0
`define IOPS_ST_TX_EMPTY 1
`define IOPS_ST_PARITY_ERR 2
`define IOPS_ST_FRAME_ERR 3
`define IOPS_ST_OVERRUN 4

`endif

/* core/iops_pkg.sv */
// Types of the I/O port select, serial and test-port block
package iops_pkg;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} iops_rx_t;

	// One processor bus cycle as seen by the decoder
	typedef struct packed {
		logic [7:0] addr;
		logic io;
		logic op;
		logic wr;
		logic wvalid;
		logic [7:0] data;
	} iops_bus_t;

	typedef struct packed {
		logic [2:0] aux_rate_s1, aux_rate, term_rate_s1, term_rate;
		logic jmp_s1, jmp, ext_s1, ext, ext_d, rx_s1, rx;
		logic [7:0] tin_s1, tin, tstat_s1, tstat;
		logic [15:0] aux_cnt, term_cnt;
		logic aux_clk, term_clk;
		logic [7:0] adp_cnt;
		logic op_d, armed, aux_en, term_en;
		logic aux_sel_n, term_sel_n, rs, adp_read;
		logic rx_rd_n, st_rd_n, tx_wr_n, ctl_wr_n;
		logic ts_rd_n, td_rd_n, tc_wr_n, td_wr_n;
		logic [7:0] dout;
		logic dout_oe_n;
		logic [7:0] link_ctl, test_ctl, test_out;
		logic [7:0] tx_hold;
		logic tx_full, tx_busy, tx_line;
		logic [11:0] tx_shift;
		logic [3:0] tx_bits;
		logic [15:0] tx_cnt;
		iops_rx_t rx_st;
		logic [15:0] rx_cnt;
		logic [3:0] rx_bits;
		logic [9:0] rx_sh;
		logic [7:0] rx_data;
		logic rx_ready, perr, ferr, oerr;
	} iops_state_t;

endpackage : iops_pkg

/* core/iops_top.sv */
// I/O port decoder with serial-adapter selects, fast serial link and test port
`timescale 1ns/10ps
`default_nettype none
`include "iops_consts.svh"

module iops_top import iops_pkg::*; #(
	parameter int CLK_HZ = `IOPS_CLK_HZ,
	parameter int LINK_BAUD = `IOPS_LINK_BAUD,
	parameter int ADAPTER_DIV = `IOPS_ADAPTER_DIV
) (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire iops_bus_t bus_i,
	input wire logic [2:0] aux_rate_sel_i,
	input wire logic [2:0] terminal_rate_sel_i,
	input wire logic aux_ext_clk_jumper_i,
	input wire logic aux_ext_clk_i,
	input wire logic link_rx_i,
	input wire logic [2:0] link_dma_status_i,
	input wire logic [7:0] test_status_i,
	input wire logic [7:0] test_data_in_bus_i,
	output logic aux_adapter_select_n_o,
	output logic terminal_adapter_select_n_o,
	output logic register_select_bit_o,
	output logic adapter_read_o,
	output logic aux_adapter_enable_o,
	output logic terminal_adapter_enable_o,
	output logic aux_serial_clk_o,
	output logic terminal_serial_clk_o,
	output logic link_tx_o,
	output logic link_rx_read_n_o,
	output logic link_status_read_n_o,
	output logic link_tx_write_n_o,
	output logic link_control_write_n_o,
	output logic [7:0] link_control_o,
	output logic test_status_read_n_o,
	output logic test_data_read_n_o,
	output logic test_control_write_n_o,
	output logic test_data_write_n_o,
	output logic [7:0] test_control_o,
	output logic [7:0] test_data_out_bus_o,
	output logic [7:0] data_o,
	output logic data_oe_n_o
);

	// ----------------------------------------
	// Derived timing
	// ----------------------------------------
	localparam int LINK_BIT = CLK_HZ / LINK_BAUD;
	localparam int SLOWEST_HALF = CLK_HZ / (2 * `IOPS_OVERSAMPLE * `IOPS_RATE_0);

	if (LINK_BIT < 4 || LINK_BIT > 65535 || SLOWEST_HALF > 65535 || ADAPTER_DIV < 2
		|| ADAPTER_DIV > 255 || CLK_HZ / (2 * `IOPS_OVERSAMPLE * `IOPS_RATE_7) < 1) begin : g_bad
		$error("iops_top: clock or rate parameters out of range");
	end

	// Half period of the 16x adapter clock for one selector position
	function automatic logic [15:0] half_count(input logic [2:0] sel);
		int rate;
		case (sel)
			3'h0: rate = `IOPS_RATE_0;
			3'h1: rate = `IOPS_RATE_1;
			3'h2: rate = `IOPS_RATE_2;
			3'h3: rate = `IOPS_RATE_3;
			3'h4: rate = `IOPS_RATE_4;
			3'h5: rate = `IOPS_RATE_5;
			3'h6: rate = `IOPS_RATE_6;
			default: rate = `IOPS_RATE_7;
		endcase
		half_count = 16'(CLK_HZ / (2 * `IOPS_OVERSAMPLE * rate));
	endfunction : half_count

	function automatic logic par_of(input logic [7:0] d, input logic odd);
		par_of = (^d) ^ odd;
	endfunction : par_of
	// Strobes, selects, the adapter read line, the read-data enable and serial lines idle high; everything else clears
	localparam iops_state_t ST_RESET = '{rx_s1: 1'b1, rx: 1'b1, aux_sel_n: 1'b1, term_sel_n: 1'b1,
		adp_read: 1'b1, rx_rd_n: 1'b1, st_rd_n: 1'b1, tx_wr_n: 1'b1, ctl_wr_n: 1'b1,
		ts_rd_n: 1'b1, td_rd_n: 1'b1, tc_wr_n: 1'b1, td_wr_n: 1'b1, dout_oe_n: 1'b1,
		tx_line: 1'b1, rx_st: RX_IDLE, default: '0};
	iops_state_t st_reg;
	iops_state_t st_next;

	// ----------------------------------------
	// Decode and next state
	// ----------------------------------------
	always_comb begin
		logic range_n;
		logic rd_ok;
		logic wr_ok;
		logic adp_tick;
		logic aux_hit;
		logic term_hit;
		logic [3:0] rx_need;
		logic [7:0] status;
		range_n = 1'b1;
		rd_ok = 1'b0;
		wr_ok = 1'b0;
		adp_tick = 1'b0;
		aux_hit = 1'b0;
		term_hit = 1'b0;
		rx_need = 4'h0;
		status = 8'h00;
		st_next = st_reg;

		// Pin synchronisers: first stage feeds only the second
		st_next.aux_rate_s1 = aux_rate_sel_i;
		st_next.aux_rate = st_reg.aux_rate_s1;
		st_next.term_rate_s1 = terminal_rate_sel_i;
		st_next.term_rate = st_reg.term_rate_s1;
		st_next.jmp_s1 = aux_ext_clk_jumper_i;
		st_next.jmp = st_reg.jmp_s1;
		st_next.ext_s1 = aux_ext_clk_i;
		st_next.ext = st_reg.ext_s1;
		st_next.ext_d = st_reg.ext;
		st_next.rx_s1 = link_rx_i;
		st_next.rx = st_reg.rx_s1;
		st_next.tin_s1 = test_data_in_bus_i;
		st_next.tin = st_reg.tin_s1;
		st_next.tstat_s1 = test_status_i;
		st_next.tstat = st_reg.tstat_s1;

		// Adapter chip selects and register select
		aux_hit = bus_i.io && bus_i.op && bus_i.addr[7:1] == `IOPS_AUX_PAIR;
		term_hit = bus_i.io && bus_i.op && bus_i.addr[7:1] == `IOPS_TERM_PAIR;
		st_next.aux_sel_n = !aux_hit;
		st_next.term_sel_n = !term_hit;
		// Adapter picks status/control or data from bit zero, direction from the bus
		st_next.rs = bus_i.addr[0];
		st_next.adp_read = !bus_i.wr;

		// Adapter enable waits for the first adapter clock after the request rises
		st_next.adp_cnt = st_reg.adp_cnt + 8'h01;
		if (st_reg.adp_cnt == 8'(ADAPTER_DIV - 1)) begin
			st_next.adp_cnt = 8'h00;
			adp_tick = 1'b1;
		end
		st_next.op_d = bus_i.op;
		if (bus_i.op && !st_reg.op_d) begin
			st_next.armed = 1'b1;
		end
		if (!bus_i.op) begin
			st_next.armed = 1'b0;
			st_next.aux_en = 1'b0;
			st_next.term_en = 1'b0;
		end else if (adp_tick && (st_reg.armed || (bus_i.op && !st_reg.op_d))) begin
			st_next.armed = 1'b0;
			st_next.aux_en = aux_hit;
			st_next.term_en = term_hit;
		end

		// Baud rate clocks: square wave at sixteen times the chosen rate, except aux at selector 0 with the jumper, which follows the external clock
		st_next.aux_cnt = st_reg.aux_cnt + 16'h0001;
		if (st_reg.aux_cnt >= half_count(st_reg.aux_rate) - 16'h0001) begin
			st_next.aux_cnt = 16'h0000;
			st_next.aux_clk = !st_reg.aux_clk;
		end
		if (st_reg.jmp && st_reg.aux_rate == 3'h0) begin
			st_next.aux_clk = st_reg.ext_d;
		end
		st_next.term_cnt = st_reg.term_cnt + 16'h0001;
		if (st_reg.term_cnt >= half_count(st_reg.term_rate) - 16'h0001) begin
			st_next.term_cnt = 16'h0000;
			st_next.term_clk = !st_reg.term_clk;
		end

		// Strobes for the E8..EF block
		range_n = !(bus_i.io && bus_i.addr[7:3] == `IOPS_RANGE_BLOCK);
		rd_ok = !range_n && bus_i.op && !bus_i.wr;
		wr_ok = !range_n && bus_i.op && bus_i.wr && bus_i.wvalid;
		st_next.rx_rd_n = !(rd_ok && bus_i.addr[2:0] == `IOPS_SUB_LINK_DATA);
		st_next.st_rd_n = !(rd_ok && bus_i.addr[2:0] == `IOPS_SUB_LINK_STAT);
		st_next.ts_rd_n = !(rd_ok && bus_i.addr[2:0] == `IOPS_SUB_TEST_STAT);
		st_next.td_rd_n = !(rd_ok && bus_i.addr[2:0] == `IOPS_SUB_TEST_DATA);
		st_next.tx_wr_n = !(wr_ok && bus_i.addr[2:0] == `IOPS_SUB_LINK_DATA);
		st_next.ctl_wr_n = !(wr_ok && bus_i.addr[2:0] == `IOPS_SUB_LINK_STAT);
		st_next.tc_wr_n = !(wr_ok && bus_i.addr[2:0] == `IOPS_SUB_TEST_STAT);
		st_next.td_wr_n = !(wr_ok && bus_i.addr[2:0] == `IOPS_SUB_TEST_DATA);
		status = {link_dma_status_i, st_reg.oerr, st_reg.ferr, st_reg.perr,
			!st_reg.tx_full, st_reg.rx_ready};
		// Read data; other ports leave the bus released
		st_next.dout_oe_n = !(rd_ok && bus_i.addr[2:0] <= `IOPS_SUB_TEST_DATA);
		st_next.dout = 8'h00;
		if (rd_ok) begin
			case (bus_i.addr[2:0])
				`IOPS_SUB_LINK_DATA: st_next.dout = st_reg.rx_data;
				`IOPS_SUB_LINK_STAT: st_next.dout = status;
				`IOPS_SUB_TEST_STAT: st_next.dout = st_reg.tstat;
				`IOPS_SUB_TEST_DATA: st_next.dout = st_reg.tin;
				default: st_next.dout = 8'h00;
			endcase
		end
		// Write latches
		if (wr_ok) begin
			case (bus_i.addr[2:0])
				`IOPS_SUB_LINK_DATA: begin
					st_next.tx_hold = bus_i.data;
					st_next.tx_full = 1'b1;
				end
				`IOPS_SUB_LINK_STAT: st_next.link_ctl = bus_i.data;
				`IOPS_SUB_TEST_STAT: st_next.test_ctl = bus_i.data;
				`IOPS_SUB_TEST_DATA: st_next.test_out = bus_i.data;
				default: st_next.tx_full = st_reg.tx_full;
			endcase
		end

		// Link transmitter: start, data LSB first, optional parity, one or two stops
		if (st_reg.tx_busy) begin
			st_next.tx_cnt = st_reg.tx_cnt + 16'h0001;
			if (st_reg.tx_cnt == 16'(LINK_BIT - 1)) begin
				st_next.tx_cnt = 16'h0000;
				st_next.tx_shift = {1'b1, st_reg.tx_shift[11:1]};
				st_next.tx_line = st_reg.tx_shift[1];
				st_next.tx_bits = st_reg.tx_bits - 4'h1;
				if (st_reg.tx_bits == 4'h1) begin
					st_next.tx_busy = 1'b0;
					st_next.tx_line = 1'b1;
				end
			end
		end else if (st_reg.tx_full) begin
			st_next.tx_busy = 1'b1;
			st_next.tx_full = !st_next.tx_wr_n && st_reg.tx_wr_n; // A fresh load here is kept
			st_next.tx_cnt = 16'h0000;
			st_next.tx_line = 1'b0;
			if (st_reg.link_ctl[`IOPS_CTL_PARITY_EN]) begin
				st_next.tx_shift = {2'b11, par_of(st_reg.tx_hold,
					st_reg.link_ctl[`IOPS_CTL_PARITY_ODD]), st_reg.tx_hold, 1'b0};
			end else begin
				st_next.tx_shift = {3'b111, st_reg.tx_hold, 1'b0};
			end
			st_next.tx_bits = 4'(1 + `IOPS_DATA_BITS + 1) + {3'h0,
				st_reg.link_ctl[`IOPS_CTL_PARITY_EN]} + {3'h0, st_reg.link_ctl[`IOPS_CTL_TWO_STOP]};
		end

		// Link receiver
		rx_need = 4'(`IOPS_DATA_BITS + 1) + {3'h0, st_reg.link_ctl[`IOPS_CTL_PARITY_EN]};
		if (!st_reg.rx_rd_n) begin
			{st_next.rx_ready, st_next.perr, st_next.ferr, st_next.oerr} = 4'h0;
		end
		case (st_reg.rx_st)
			RX_IDLE: begin
				st_next.rx_cnt = 16'h0000;
				if (!st_reg.rx) begin
					st_next.rx_st = RX_START;
				end
			end
			RX_START: begin
				st_next.rx_cnt = st_reg.rx_cnt + 16'h0001;
				if (st_reg.rx_cnt == 16'(LINK_BIT / 2 - 1)) begin
					st_next.rx_cnt = 16'h0000;
					st_next.rx_bits = 4'h0;
					st_next.rx_st = st_reg.rx ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				st_next.rx_cnt = st_reg.rx_cnt + 16'h0001;
				if (st_reg.rx_cnt == 16'(LINK_BIT - 1)) begin
					st_next.rx_cnt = 16'h0000;
					st_next.rx_sh[st_reg.rx_bits] = st_reg.rx;
					st_next.rx_bits = st_reg.rx_bits + 4'h1;
					if (st_reg.rx_bits == rx_need - 4'h1) begin
						// Errors and ready are set after the read clear: set wins
						st_next.rx_st = RX_IDLE;
						st_next.rx_data = st_reg.rx_sh[7:0];
						st_next.rx_ready = 1'b1;
						st_next.oerr = st_reg.rx_ready && st_reg.rx_rd_n;
						st_next.ferr = !st_reg.rx;
						st_next.perr = st_reg.link_ctl[`IOPS_CTL_PARITY_EN] &&
							(st_reg.rx_sh[8] != par_of(st_reg.rx_sh[7:0],
							st_reg.link_ctl[`IOPS_CTL_PARITY_ODD]));
					end
				end
			end
			default: st_next.rx_st = RX_IDLE;
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_reg <= ST_RESET;
		end else begin
			st_reg <= st_next;
		end
	end
	assign aux_adapter_select_n_o = st_reg.aux_sel_n;
	assign terminal_adapter_select_n_o = st_reg.term_sel_n;
	assign register_select_bit_o = st_reg.rs;
	assign adapter_read_o = st_reg.adp_read;
	assign aux_adapter_enable_o = st_reg.aux_en;
	assign terminal_adapter_enable_o = st_reg.term_en;
	assign aux_serial_clk_o = st_reg.aux_clk;
	assign terminal_serial_clk_o = st_reg.term_clk;
	assign link_tx_o = st_reg.tx_line;
	assign link_rx_read_n_o = st_reg.rx_rd_n;
	assign link_status_read_n_o = st_reg.st_rd_n;
	assign link_tx_write_n_o = st_reg.tx_wr_n;
	assign link_control_write_n_o = st_reg.ctl_wr_n;
	assign link_control_o = st_reg.link_ctl;
	assign test_status_read_n_o = st_reg.ts_rd_n;
	assign test_data_read_n_o = st_reg.td_rd_n;
	assign test_control_write_n_o = st_reg.tc_wr_n;
	assign test_data_write_n_o = st_reg.td_wr_n;
	assign test_control_o = st_reg.test_ctl;
	assign test_data_out_bus_o = st_reg.test_out;
	assign data_o = st_reg.dout;
	assign data_oe_n_o = st_reg.dout_oe_n;

endmodule : iops_top
`default_nettype wire

/* verification/iops_top_properties.sv */
// Checker for the port decoder, strobes, latches and adapter enables
`timescale 1ns/10ps
`default_nettype none
module iops_top_checker import iops_pkg::*; #(
	parameter int ADAPTER_DIV = 16
) (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire iops_bus_t bus_i,
	input wire logic aux_adapter_select_n_o,
	input wire logic terminal_adapter_select_n_o,
	input wire logic register_select_bit_o,
	input wire logic adapter_read_o,
	input wire logic aux_adapter_enable_o,
	input wire logic terminal_adapter_enable_o,
	input wire logic link_rx_read_n_o,
	input wire logic link_status_read_n_o,
	input wire logic link_tx_write_n_o,
	input wire logic test_status_read_n_o,
	input wire logic test_data_read_n_o,
	input wire logic test_control_write_n_o,
	input wire logic link_control_write_n_o,
	input wire logic [7:0] link_control_o,
	input wire logic test_data_write_n_o,
	input wire logic [7:0] test_control_o,
	input wire logic [7:0] test_data_out_bus_o,
	input wire logic data_oe_n_o
);
	// Enable waits for the next free-running divider tick, one cycle of slack
	localparam int EN_MAX = ADAPTER_DIV + 1;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	logic io_op, hit_aux, hit_term, rd_blk, wr_q;
	assign io_op = bus_i.io && bus_i.op;
	assign hit_aux = io_op && bus_i.addr[7:1] == 7'h66;
	assign hit_term = io_op && bus_i.addr[7:1] == 7'h67;
	assign rd_blk = io_op && !bus_i.wr && bus_i.addr[7:2] == 6'h3a;
	assign wr_q = io_op && bus_i.wr && bus_i.wvalid;
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_aux_select_decode: assert property (aux_adapter_select_n_o == !$past(hit_aux))
		else $error("aux select wrong");
	a_term_select_decode: assert property (terminal_adapter_select_n_o == !$past(hit_term))
		else $error("terminal select wrong");
	a_register_select_bit: assert property (hit_aux || hit_term |=>
		register_select_bit_o == $past(bus_i.addr[0]) && adapter_read_o == !$past(bus_i.wr))
		else $error("register select or read line wrong");
	a_link_rx_strobe: assert property (link_rx_read_n_o == !$past(rd_blk && bus_i.addr[1:0] == 2'h0))
		else $error("link read strobe wrong");
	a_link_ctl_latch: assert property (wr_q && bus_i.addr == 8'he9 |=>
		!link_control_write_n_o && link_control_o == $past(bus_i.data))
		else $error("link control latch wrong");
	a_link_ctl_hold: assert property ($changed(link_control_o) |-> $past(wr_q && bus_i.addr == 8'he9))
		else $error("link control changed without write");
	a_test_ctl_latch: assert property (wr_q && bus_i.addr == 8'hea |=> test_control_o == $past(bus_i.data))
		else $error("test control latch wrong");
	a_test_data_write: assert property (wr_q && bus_i.addr == 8'heb |=>
		!test_data_write_n_o && test_data_out_bus_o == $past(bus_i.data))
		else $error("test data latch wrong");
	a_test_out_hold: assert property ($changed(test_data_out_bus_o) |-> !test_data_write_n_o)
		else $error("test data out changed without strobe");
	a_drive_window: assert property (data_oe_n_o == !$past(rd_blk))
		else $error("data bus drive wrong");
	a_enable_after_req: assert property ($rose(bus_i.op) && hit_aux |-> ##[1:EN_MAX] aux_adapter_enable_o)
		else $error("aux enable late");
	a_enable_off: assert property ($fell(bus_i.op) |-> ##[1:2] !aux_adapter_enable_o && !terminal_adapter_enable_o)
		else $error("adapter enable stuck");
	a_read_strobes: assert property ({link_status_read_n_o, test_status_read_n_o,
		test_data_read_n_o} == ~$past({rd_blk && bus_i.addr[1:0] == 2'h1,
		rd_blk && bus_i.addr[1:0] == 2'h2, rd_blk && bus_i.addr[1:0] == 2'h3}))
		else $error("read strobe wrong");
	a_write_strobes: assert property ({link_tx_write_n_o, test_control_write_n_o} ==
		~$past({wr_q && bus_i.addr == 8'he8, wr_q && bus_i.addr == 8'hea}))
		else $error("write strobe wrong");
	a_term_enable: assert property ($rose(bus_i.op) && hit_term |-> ##[1:EN_MAX] terminal_adapter_enable_o)
		else $error("terminal enable late");
	c_test_write: cover property (wr_q && bus_i.addr == 8'hea);
	c_block_read: cover property (!data_oe_n_o);
	c_aux_enable: cover property ($rose(aux_adapter_enable_o));
endmodule : iops_top_checker
bind iops_top iops_top_checker #(.ADAPTER_DIV(ADAPTER_DIV)) chk (.mclk_i(mclk_i), .nrst_i(nrst_i),
	.bus_i(bus_i), .aux_adapter_select_n_o(aux_adapter_select_n_o),
	.terminal_adapter_select_n_o(terminal_adapter_select_n_o),
	.register_select_bit_o(register_select_bit_o), .adapter_read_o(adapter_read_o),
	.aux_adapter_enable_o(aux_adapter_enable_o), .terminal_adapter_enable_o(terminal_adapter_enable_o),
	.link_rx_read_n_o(link_rx_read_n_o), .link_control_write_n_o(link_control_write_n_o),
	.link_status_read_n_o(link_status_read_n_o), .link_tx_write_n_o(link_tx_write_n_o),
	.test_status_read_n_o(test_status_read_n_o), .test_data_read_n_o(test_data_read_n_o),
	.test_control_write_n_o(test_control_write_n_o),
	.link_control_o(link_control_o), .test_data_write_n_o(test_data_write_n_o),
	.test_control_o(test_control_o), .test_data_out_bus_o(test_data_out_bus_o),
	.data_oe_n_o(data_oe_n_o));
`default_nettype wire

/* verification/iops_cpu_model.sv */
// Processor bus master model for the I/O port decoder
`timescale 1ns/10ps
`default_nettype none
module iops_cpu_model import iops_pkg::*; (
	input wire logic mclk_i,
	input wire logic [7:0] data_i,
	input wire logic data_oe_n_i,
	output iops_bus_t bus_o
);
	iops_bus_t bus_q = '0;
	assign bus_o = bus_q;
	// Released data lines show the inverse so a stale byte never passes
	task automatic cycle(input logic [7:0] addr, input logic wr, input logic wv,
		input logic [7:0] wd, input int hold, output logic [7:0] rd, output logic oen);
		@(posedge mclk_i);
		bus_q <= '{addr: addr, io: 1'b1, op: 1'b1, wr: wr, wvalid: wv, data: wd};
		repeat (hold) @(posedge mclk_i);
		rd = data_i;
		oen = data_oe_n_i;
		bus_q <= '{addr: addr, io: 1'b0, op: 1'b0, wr: 1'b0, wvalid: 1'b0, data: ~wd};
	endtask : cycle
endmodule : iops_cpu_model
`default_nettype wire

/* verification/tb_iops_top.sv */
// Self-checking bench for the I/O port decoder block
`timescale 1ns/10ps
`default_nettype none
module tb_iops_top import iops_pkg::*; ;
	// Scaled clock gives a 10-cycle link bit and exact adapter rates for all but 110 baud
	localparam int CLK_HZ = 1536000;
	localparam int LBIT = CLK_HZ / 153600;
	logic mclk_i, nrst_i, jmp, rx_line, oe_n, tx, aclk, tclk;
	logic ext_clk = 1'b0;
	logic [2:0] aux_rate, term_rate, dma;
	logic [7:0] tstat, tdin, data_o, lctl, tctl, tout;
	iops_bus_t bus;
	int fails = 0;
	int total_checks = 0;
	int ext_cnt = 0;
	iops_cpu_model cpu (.mclk_i(mclk_i), .data_i(data_o), .data_oe_n_i(oe_n), .bus_o(bus));
	iops_top #(.CLK_HZ(CLK_HZ)) uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .bus_i(bus),
		.aux_rate_sel_i(aux_rate), .terminal_rate_sel_i(term_rate), .aux_ext_clk_jumper_i(jmp),
		.aux_ext_clk_i(ext_clk), .link_rx_i(rx_line), .link_dma_status_i(dma),
		.test_status_i(tstat), .test_data_in_bus_i(tdin), .aux_adapter_select_n_o(),
		.terminal_adapter_select_n_o(), .register_select_bit_o(), .adapter_read_o(),
		.aux_adapter_enable_o(), .terminal_adapter_enable_o(), .aux_serial_clk_o(aclk),
		.terminal_serial_clk_o(tclk), .link_tx_o(tx), .link_rx_read_n_o(),
		.link_status_read_n_o(), .link_tx_write_n_o(), .link_control_write_n_o(),
		.link_control_o(lctl), .test_status_read_n_o(), .test_data_read_n_o(),
		.test_control_write_n_o(), .test_data_write_n_o(), .test_control_o(tctl),
		.test_data_out_bus_o(tout), .data_o(data_o), .data_oe_n_o(oe_n));
	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		ext_cnt <= (ext_cnt == 11) ? 0 : ext_cnt + 1;
		if (ext_cnt == 11) ext_clk <= ~ext_clk;
	end
	// ----------------------------------------
	// Compare and closing tasks
	// ----------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic check_int(input int got, input int exp);
		total_checks++;
		if (got != exp) begin
			fails++;
			$display("CHECK FAILED at %0t: count %0d expected %0d", $time, got, exp);
		end
	endtask : check_int
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset_values();
		@(negedge mclk_i);
		check({lctl, tctl}, 16'h0);
		check({tout, 6'h0, tx, oe_n}, 16'h3);
	endtask : t_reset_values
	task automatic t_ports();
		logic [7:0] rd;
		logic oen;
		cpu.cycle(8'he9, 1'b1, 1'b1, 8'h01, 1, rd, oen);
		cpu.cycle(8'hea, 1'b1, 1'b1, 8'h5a, 1, rd, oen);
		cpu.cycle(8'heb, 1'b1, 1'b1, 8'hc3, 1, rd, oen);
		cpu.cycle(8'heb, 1'b1, 1'b0, 8'h77, 1, rd, oen);
		cpu.cycle(8'hef, 1'b1, 1'b1, 8'h11, 1, rd, oen);
		@(negedge mclk_i);
		check({lctl, tctl}, 16'h015a);
		check(tout, 8'hc3);
		cpu.cycle(8'hea, 1'b0, 1'b0, 8'h00, 2, rd, oen);
		check({oen, rd}, {1'b0, tstat});
		cpu.cycle(8'heb, 1'b0, 1'b0, 8'h00, 2, rd, oen);
		check({oen, rd}, {1'b0, tdin});
		cpu.cycle(8'he9, 1'b0, 1'b0, 8'h00, 2, rd, oen);
		check({oen, rd}, {1'b0, dma, 5'h02});
		cpu.cycle(8'hec, 1'b0, 1'b0, 8'h00, 2, rd, oen);
		check(oen, 1'b1);
	endtask : t_ports
	task automatic t_adapters();
		logic [7:0] rd;
		logic oen;
		int a;
		for (a = 8'hcc; a <= 8'hcf; a++) begin
			cpu.cycle(a[7:0], 1'b0, 1'b0, 8'h00, 20, rd, oen);
			check(oen, 1'b1);
			cpu.cycle(a[7:0], 1'b1, 1'b1, 8'h42, 20, rd, oen);
		end
	endtask : t_adapters
	task automatic t_link_tx();
		logic [10:0] got;
		logic [7:0] rd;
		logic oen;
		int k;
		got = '0;
		cpu.cycle(8'he8, 1'b1, 1'b1, 8'h3d, 1, rd, oen);
		for (k = 0; k < 40 && tx !== 1'b0; k++) @(negedge mclk_i);
		repeat (LBIT / 2) @(negedge mclk_i);
		for (k = 0; k < 11; k++) begin
			got[k] = tx;
			repeat (LBIT) @(negedge mclk_i);
		end
		check(got, {1'b1, ^8'h3d, 8'h3d, 1'b0});
	endtask : t_link_tx
	task automatic send_frame(input logic [7:0] d, input logic stop, input logic bad_par);
		logic [10:0] f;
		int k;
		f = {stop, ^d ^ bad_par, d, 1'b0};
		for (k = 0; k < 11; k++) begin
			@(posedge mclk_i);
			rx_line <= f[k];
			repeat (LBIT - 1) @(posedge mclk_i);
		end
		@(posedge mclk_i);
		rx_line <= 1'b1;
		repeat (3 * LBIT) @(posedge mclk_i);
	endtask : send_frame
	task automatic t_link_rx();
		logic [7:0] rd;
		logic oen;
		send_frame(8'ha5, 1'b1, 1'b0);
		cpu.cycle(8'he9, 1'b0, 1'b0, 8'h00, 2, rd, oen);
		check(rd, {dma, 5'h03});
		cpu.cycle(8'he8, 1'b0, 1'b0, 8'h00, 2, rd, oen);
		check(rd, 8'ha5);
		cpu.cycle(8'he9, 1'b0, 1'b0, 8'h00, 2, rd, oen);
		check(rd, {dma, 5'h02});
		send_frame(8'h5a, 1'b0, 1'b0);
		cpu.cycle(8'he9, 1'b0, 1'b0, 8'h00, 2, rd, oen);
		check(rd & 8'h0c, 8'h08);
		cpu.cycle(8'he8, 1'b0, 1'b0, 8'h00, 2, rd, oen);
		send_frame(8'h33, 1'b1, 1'b1);
		cpu.cycle(8'he9, 1'b0, 1'b0, 8'h00, 2, rd, oen);
		check(rd & 8'h0c, 8'h04);
	endtask : t_link_rx
	task automatic measure(input logic use_aux, output int per);
		logic prev, now;
		int n, edges;
		per = 0;
		edges = 0;
		prev = 1'b1;
		for (n = 0; n < 4000 && edges < 2; n++) begin
			@(negedge mclk_i);
			now = use_aux ? aclk : tclk;
			if (edges == 1) per++;
			if (now === 1'b1 && prev === 1'b0) edges++;
			prev = now;
		end
	endtask : measure
	task automatic t_rates();
		int per, r;
		int baud [8] = '{110, 150, 300, 600, 1200, 2400, 4800, 9600};
		for (r = 1; r < 8; r++) begin
			@(posedge mclk_i);
			term_rate <= r[2:0];
			measure(1'b0, per);
			measure(1'b0, per);
			check_int(per, CLK_HZ / (baud[r] * 16));
		end
		@(posedge mclk_i);
		aux_rate <= 3'h0;
		jmp <= 1'b1;
		measure(1'b1, per);
		measure(1'b1, per);
		check_int(per, 24);
		@(posedge mclk_i);
		aux_rate <= 3'h7;
		jmp <= 1'b0;
		measure(1'b1, per);
		measure(1'b1, per);
		check_int(per, CLK_HZ / (9600 * 16));
	endtask : t_rates
	initial begin
		nrst_i = 1'b0;
		jmp = 1'b0;
		rx_line = 1'b1;
		aux_rate = 3'h7;
		term_rate = 3'h7;
		dma = 3'h5;
		tstat = 8'h3c;
		tdin = 8'h96;
		repeat (6) @(posedge mclk_i);
		nrst_i <= 1'b1;
		t_reset_values();
		t_ports();
		t_adapters();
		t_link_tx();
		t_link_rx();
		t_rates();
		complete_run();
	end
	initial begin
		#1000000;
		fails++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		complete_run();
	end
endmodule : tb_iops_top
`default_nettype wire
